// >>> rtl/dioem_pkg.sv
// Shared constants, types and helpers for the discrete I/O event mapper
// Function
// - Eight sense inputs, each one action.
// - Fire action when input reaches active level.
// - No action: input ignored, polarity active low.
// - Span input activation selects span calibration.
// - Zero input activation selects zero calibration.
// - Per-input polarity, high or low active.
// - Eight alarm outputs, each one mapped state.
// - Alarm active exactly while mapped state holds.
// - Per-output polarity, high or low active.
// - Alarm mapped to none never activates.
// - Each fault state active while fault present.
// - Summary fault active while any fault present.
// - Background, span, zero states follow calibration phase.
// - Storage-detached state active while memory disconnected.
// - Maintenance state active while maintenance engaged.
// - Three over-range states follow analog channel scale.
// - Enter over-range at 90%, leave at 80%.
package dioem_pkg;

    localparam int SENSE_COUNT = 8;
    localparam int ALARM_COUNT = 8;
    localparam int OVR_CHANNELS = 3;
    localparam int READ_WIDTH = 16;

    // Hysteresis thresholds as percent of the standard range
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] PCT_ENTER = 7'h5a;
    localparam logic [6:0] PCT_LEAVE = 7'h50;

    // Values after reset
    localparam logic [SENSE_COUNT-1:0] SYNC_RESET = 8'h00;
    localparam logic [SENSE_COUNT-1:0] PREV_LEVEL_RESET = 8'hff;
    localparam logic [SENSE_COUNT-1:0] POLARITY_RESET = 8'h00;
    localparam logic [ALARM_COUNT-1:0] ALARM_RESET = 8'hff;
    localparam logic [OVR_CHANNELS-1:0] OVERSCALE_RESET = 3'h0;

    typedef enum logic [1:0] {ACT_NONE, ACT_SPAN, ACT_ZERO} dioem_action_e;

    typedef enum logic [1:0] {CAL_MEASURE, CAL_SPAN, CAL_ZERO} dioem_cal_e;

    typedef enum logic [4:0] {
        ALM_NONE, ALM_HIGH_VOLT, ALM_SUPPLY, ALM_REFERENCE, ALM_CONVERTER,
        ALM_FLOW, ALM_CELL_HEAT, ALM_CONV_HEAT, ALM_MANIFOLD_HEAT,
        ALM_CHASSIS_TEMP, ALM_COOLER, ALM_STORAGE_DETACHED, ALM_BACKGROUND,
        ALM_SPAN, ALM_ZERO, ALM_SUMMARY, ALM_MAINTENANCE,
        ALM_OVERSCALE_CHANNEL_ZERO, ALM_OVERSCALE_CHANNEL_ONE,
        ALM_OVERSCALE_CHANNEL_TWO
    } dioem_alarm_e;

    // Map a logical level onto a pin level, or a pin level onto activity
    function automatic logic dioem_polar(input logic v,
                                         input logic activeHigh);
        return activeHigh ? v : !v;
    endfunction

endpackage

// >>> rtl/dioem_evt_if.sv
// Event and scale signals passed between the mapper's own modules
`timescale 1ns/1ns
`default_nettype none
interface dioem_evt_if;
    import dioem_pkg::*;
    logic spanReq;
    logic zeroReq;
    logic [OVR_CHANNELS-1:0] overScale;
    modport sense (output spanReq, output zeroReq);
    modport range (output overScale);
    modport core (input spanReq, input zeroReq, input overScale);
endinterface
`default_nettype wire

// >>> rtl/dioem_sense.sv
// Sense input synchroniser, polarity and activation detector
`timescale 1ns/1ns
`default_nettype none
module dioem_sense
    import dioem_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [SENSE_COUNT-1:0] senseLineN,
    input wire dioem_action_e actionCfg [SENSE_COUNT],
    input wire logic [SENSE_COUNT-1:0] activeHighCfg,
    dioem_evt_if.sense evt
);
    logic [SENSE_COUNT-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic [SENSE_COUNT-1:0] prev_q, prev_d, lvl;
    logic spanReq_q, spanReq_d, zeroReq_q, zeroReq_d, allNone;

    // Two-stage synchroniser, then activity; none forces active low
    always_comb begin
        sync1_d = rst ? SYNC_RESET : senseLineN;
        sync2_d = rst ? SYNC_RESET : sync1_q;
        spanReq_d = 1'b0;
        zeroReq_d = 1'b0;
        allNone = 1'b1;
        for (int i = 0; i < SENSE_COUNT; i++) begin
            lvl[i] = dioem_polar(sync2_q[i], activeHighCfg[i]
                                 && actionCfg[i] != ACT_NONE);
            allNone = allNone && actionCfg[i] == ACT_NONE;
            // Only the entry into the active level counts
            if (lvl[i] && !prev_q[i]) begin
                spanReq_d = spanReq_d || actionCfg[i] == ACT_SPAN;
                zeroReq_d = zeroReq_d || actionCfg[i] == ACT_ZERO;
            end
        end
        // Lines already active at reset wait for a fresh activation
        prev_d = rst ? PREV_LEVEL_RESET : lvl;
        if (rst) begin
            spanReq_d = 1'b0;
            zeroReq_d = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
        prev_q <= prev_d;
        spanReq_q <= spanReq_d;
        zeroReq_q <= zeroReq_d;
    end

    assign evt.spanReq = spanReq_q;
    assign evt.zeroReq = zeroReq_q;

    property p_span_fire;
        @(posedge clk) disable iff (rst)
        !$past(rst) && actionCfg[0] == ACT_SPAN && $stable(actionCfg[0])
        && $stable(activeHighCfg[0]) && $changed(sync2_q[0])
        && sync2_q[0] == activeHighCfg[0] |=> spanReq_q;
    endproperty
    a_span_fire: assert property (p_span_fire) else $error("no span");

    property p_once;
        @(posedge clk) disable iff (rst)
        lvl == prev_q |=> !spanReq_q && !zeroReq_q;
    endproperty
    a_once: assert property (p_once) else $error("repeat fire");

    property p_none_quiet;
        @(posedge clk) disable iff (rst)
        allNone |=> !spanReq_q && !zeroReq_q;
    endproperty
    a_none_quiet: assert property (p_none_quiet) else $error("fired");
endmodule
`default_nettype wire

// >>> rtl/dioem_range.sv
// Over-range scale tracker with hysteresis for the analog channels
`timescale 1ns/1ns
`default_nettype none
module dioem_range
    import dioem_pkg::*;
#(
    parameter int W = READ_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] reading [OVR_CHANNELS],
    input wire logic [W-1:0] fullScale [OVR_CHANNELS],
    input wire logic [OVR_CHANNELS-1:0] enable,
    dioem_evt_if.range evt
);
    logic [OVR_CHANNELS-1:0] over_q, over_d;

    // Percent product, wide enough that no bit is lost
    function automatic logic [W+6:0] scaled(input logic [W-1:0] v,
                                            input logic [6:0] pct);
        return (W+7)'(v) * (W+7)'(pct);
    endfunction

    // Enter at the upper threshold, leave at the lower, hold between
    always_comb begin
        over_d = over_q;
        for (int c = 0; c < OVR_CHANNELS; c++) begin
            if (!enable[c])
                over_d[c] = 1'b0;
            else if (scaled(reading[c], PCT_FULL)
                     >= scaled(fullScale[c], PCT_ENTER))
                over_d[c] = 1'b1;
            else if (scaled(reading[c], PCT_FULL)
                     <= scaled(fullScale[c], PCT_LEAVE))
                over_d[c] = 1'b0;
        end
        if (rst)
            over_d = OVERSCALE_RESET;
    end

    // Scale state register
    always_ff @(posedge clk) begin
        over_q <= over_d;
    end

    assign evt.overScale = over_q;

    property p_leave;
        @(posedge clk) disable iff (rst)
        scaled(reading[0], PCT_FULL) <= scaled(fullScale[0], PCT_LEAVE)
        && scaled(reading[0], PCT_FULL) < scaled(fullScale[0], PCT_ENTER)
        |=> !over_q[0];
    endproperty
    a_leave: assert property (p_leave) else $error("scale kept");
endmodule
`default_nettype wire

// >>> rtl/dioem_top.sv
// Discrete I/O event mapper: sense actions and alarm output mapping
`timescale 1ns/1ns
`default_nettype none
module dioem_top
    import dioem_pkg::*;
#(
    parameter int W = READ_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    // Raw sense lines from the connector
    input wire logic [SENSE_COUNT-1:0] senseLineN,
    // Configuration, captured while cfgLoad is high
    input wire logic cfgLoad,
    input wire dioem_action_e senseActionIn [SENSE_COUNT],
    input wire logic [SENSE_COUNT-1:0] senseActiveHighIn,
    input wire dioem_alarm_e alarmSelectIn [ALARM_COUNT],
    input wire logic [ALARM_COUNT-1:0] alarmActiveHighIn,
    // Instrument fault conditions
    input wire logic highVoltFault,
    input wire logic supplyFault,
    input wire logic referenceFault,
    input wire logic converterFaultState,
    input wire logic flowFault,
    input wire logic cellHeatFault,
    input wire logic converterHeatFault,
    input wire logic manifoldHeatFault,
    input wire logic chassisTempFault,
    input wire logic coolerFault,
    // Other instrument conditions
    input wire logic storageDetached,
    input wire logic maintenanceActive,
    input wire logic backgroundActive,
    input wire logic spanActive,
    input wire logic zeroActive,
    input wire logic calComplete,
    // Analog output channels
    input wire logic [W-1:0] aoReading [OVR_CHANNELS],
    input wire logic [W-1:0] aoStandardFull [OVR_CHANNELS],
    input wire logic [OVR_CHANNELS-1:0] overRangeEnable,
    // Results
    output var dioem_cal_e calSelect,
    output logic calStart,
    output logic [ALARM_COUNT-1:0] alarmLine,
    output logic [OVR_CHANNELS-1:0] overScale
);
    dioem_evt_if evt ();

    dioem_action_e senseAction_q [SENSE_COUNT];
    dioem_action_e senseAction_d [SENSE_COUNT];
    logic [SENSE_COUNT-1:0] senseActiveHigh_q, senseActiveHigh_d;
    dioem_alarm_e alarmSelect_q [ALARM_COUNT];
    dioem_alarm_e alarmSelect_d [ALARM_COUNT];
    logic [ALARM_COUNT-1:0] alarmActiveHigh_q, alarmActiveHigh_d;
    dioem_cal_e calSelect_q, calSelect_d;
    logic calStart_q, calStart_d;
    logic [ALARM_COUNT-1:0] alarmLine_q, alarmLine_d;
    logic anyFault;

    // Sense inputs: synchronise and detect activations
    dioem_sense u_sense (
        .clk(clk),
        .rst(rst),
        .senseLineN(senseLineN),
        .actionCfg(senseAction_q),
        .activeHighCfg(senseActiveHigh_q),
        .evt(evt.sense)
    );

    // Over-range tracking of the three analog channels
    dioem_range #(
        .W(W)
    ) u_range (
        .clk(clk),
        .rst(rst),
        .reading(aoReading),
        .fullScale(aoStandardFull),
        .enable(overRangeEnable),
        .evt(evt.range)
    );

    // Configuration registers; reset maps everything to none
    always_comb begin
        senseAction_d = senseAction_q;
        senseActiveHigh_d = senseActiveHigh_q;
        alarmSelect_d = alarmSelect_q;
        alarmActiveHigh_d = alarmActiveHigh_q;
        if (rst) begin
            for (int i = 0; i < SENSE_COUNT; i++)
                senseAction_d[i] = ACT_NONE;
            for (int i = 0; i < ALARM_COUNT; i++)
                alarmSelect_d[i] = ALM_NONE;
            senseActiveHigh_d = POLARITY_RESET;
            alarmActiveHigh_d = POLARITY_RESET;
        end else if (cfgLoad) begin
            senseAction_d = senseActionIn;
            senseActiveHigh_d = senseActiveHighIn;
            alarmSelect_d = alarmSelectIn;
            alarmActiveHigh_d = alarmActiveHighIn;
        end
    end

    // Configuration storage
    always_ff @(posedge clk) begin
        senseAction_q <= senseAction_d;
        senseActiveHigh_q <= senseActiveHigh_d;
        alarmSelect_q <= alarmSelect_d;
        alarmActiveHigh_q <= alarmActiveHigh_d;
    end

    // Summary fault mirrors the front-panel fault light
    assign anyFault = highVoltFault || supplyFault || referenceFault
        || converterFaultState || flowFault || cellHeatFault
        || converterHeatFault || manifoldHeatFault || chassisTempFault
        || coolerFault;

    // Instrument condition behind one alarm selection
    function automatic logic stateOf(input dioem_alarm_e sel);
        unique case (sel)
            ALM_NONE: return 1'b0;
            ALM_HIGH_VOLT: return highVoltFault;
            ALM_SUPPLY: return supplyFault;
            ALM_REFERENCE: return referenceFault;
            ALM_CONVERTER: return converterFaultState;
            ALM_FLOW: return flowFault;
            ALM_CELL_HEAT: return cellHeatFault;
            ALM_CONV_HEAT: return converterHeatFault;
            ALM_MANIFOLD_HEAT: return manifoldHeatFault;
            ALM_CHASSIS_TEMP: return chassisTempFault;
            ALM_COOLER: return coolerFault;
            ALM_STORAGE_DETACHED: return storageDetached;
            ALM_BACKGROUND: return backgroundActive;
            ALM_SPAN: return spanActive;
            ALM_ZERO: return zeroActive;
            ALM_SUMMARY: return anyFault;
            ALM_MAINTENANCE: return maintenanceActive;
            ALM_OVERSCALE_CHANNEL_ZERO: return evt.overScale[0];
            ALM_OVERSCALE_CHANNEL_ONE: return evt.overScale[1];
            ALM_OVERSCALE_CHANNEL_TWO: return evt.overScale[2];
            // Unused codes stay inactive rather than guess a state
            default: return 1'b0;
        endcase
    endfunction

    // Alarm pins: mapped state through per-pin polarity
    always_comb begin
        alarmLine_d = ALARM_RESET;
        if (!rst) begin
            for (int i = 0; i < ALARM_COUNT; i++)
                alarmLine_d[i] = dioem_polar(stateOf(alarmSelect_q[i]),
                                             alarmActiveHigh_q[i]);
        end
    end

    // Alarm pin registers
    always_ff @(posedge clk) begin
        alarmLine_q <= alarmLine_d;
    end

    // Calibration selector; span wins when both fire together
    always_comb begin
        calSelect_d = calSelect_q;
        calStart_d = 1'b0;
        if (rst) begin
            calSelect_d = CAL_MEASURE;
        end else if (evt.spanReq) begin
            calSelect_d = CAL_SPAN;
            calStart_d = 1'b1;
        end else if (evt.zeroReq) begin
            calSelect_d = CAL_ZERO;
            calStart_d = 1'b1;
        end else if (calComplete) begin
            calSelect_d = CAL_MEASURE;
        end
    end

    // Selector registers
    always_ff @(posedge clk) begin
        calSelect_q <= calSelect_d;
        calStart_q <= calStart_d;
    end

    // Outputs come directly from their registers
    assign calSelect = calSelect_q;
    assign calStart = calStart_q;
    assign alarmLine = alarmLine_q;
    assign overScale = evt.overScale;

    property p_span_sel;
        @(posedge clk) disable iff (rst)
        evt.spanReq |=> calSelect == CAL_SPAN && calStart;
    endproperty
    a_span_sel: assert property (p_span_sel) else $error("no span sel");

    property p_zero_sel;
        @(posedge clk) disable iff (rst)
        evt.zeroReq && !evt.spanReq |=> calSelect == CAL_ZERO && calStart;
    endproperty
    a_zero_sel: assert property (p_zero_sel) else $error("no zero sel");

    property p_none_out;
        @(posedge clk) disable iff (rst)
        alarmSelect_q[0] == ALM_NONE
        |=> alarmLine[0] == !$past(alarmActiveHigh_q[0]);
    endproperty
    a_none_out: assert property (p_none_out) else $error("none on");

    property p_summary;
        @(posedge clk) disable iff (rst)
        anyFault && alarmSelect_q[1] == ALM_SUMMARY && alarmActiveHigh_q[1]
        |=> alarmLine[1];
    endproperty
    a_summary: assert property (p_summary) else $error("summary low");

    property p_maint_low;
        @(posedge clk) disable iff (rst)
        maintenanceActive && alarmSelect_q[2] == ALM_MAINTENANCE
        && !alarmActiveHigh_q[2] |=> !alarmLine[2];
    endproperty
    a_maint_low: assert property (p_maint_low) else $error("maint");

    property p_fault_clear;
        @(posedge clk) disable iff (rst)
        !converterFaultState && alarmSelect_q[4] == ALM_CONVERTER
        && alarmActiveHigh_q[4] |=> !alarmLine[4];
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("stuck");

    property p_overscale;
        @(posedge clk) disable iff (rst)
        evt.overScale[0] && alarmSelect_q[3] == ALM_OVERSCALE_CHANNEL_ZERO
        && alarmActiveHigh_q[3] |=> alarmLine[3];
    endproperty
    a_overscale: assert property (p_overscale) else $error("no ovr");

    // One pin and one code per alarm pin check, with both polarities covered
    property p_cal_hold;
        @(posedge clk) disable iff (rst)
        !evt.spanReq && !evt.zeroReq && !calComplete
        |=> calSelect == $past(calSelect) && !calStart;
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("sel moved");

    property p_cfg_take;
        @(posedge clk) disable iff (rst)
        cfgLoad |=> alarmActiveHigh_q == $past(alarmActiveHighIn)
        && senseActiveHigh_q == $past(senseActiveHighIn);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("cfg lost");

    property p_hv_fault;
        @(posedge clk) disable iff (rst)
        highVoltFault && alarmSelect_q[7] == ALM_HIGH_VOLT
        && alarmActiveHigh_q[7] |=> alarmLine[7];
    endproperty
    a_hv_fault: assert property (p_hv_fault) else $error("hv low");

    property p_storage;
        @(posedge clk) disable iff (rst)
        storageDetached && alarmSelect_q[6] == ALM_STORAGE_DETACHED
        && !alarmActiveHigh_q[6] |=> !alarmLine[6];
    endproperty
    a_storage: assert property (p_storage) else $error("detach pin");

    property p_span_st;
        @(posedge clk) disable iff (rst)
        spanActive && alarmSelect_q[5] == ALM_SPAN
        && alarmActiveHigh_q[5] |=> alarmLine[5];
    endproperty
    a_span_st: assert property (p_span_st) else $error("span pin");

    property p_ovr_low;
        @(posedge clk) disable iff (rst)
        evt.overScale[1] && alarmSelect_q[0] == ALM_OVERSCALE_CHANNEL_ONE
        && !alarmActiveHigh_q[0] |=> !alarmLine[0];
    endproperty
    a_ovr_low: assert property (p_ovr_low) else $error("ovr pin");

    property p_bkg_clr;
        @(posedge clk) disable iff (rst)
        !backgroundActive && alarmSelect_q[6] == ALM_BACKGROUND
        && !alarmActiveHigh_q[6] |=> alarmLine[6];
    endproperty
    a_bkg_clr: assert property (p_bkg_clr) else $error("bkg pin");

    property p_sum_clr;
        @(posedge clk) disable iff (rst)
        !anyFault && alarmSelect_q[1] == ALM_SUMMARY
        && alarmActiveHigh_q[1] |=> !alarmLine[1];
    endproperty
    a_sum_clr: assert property (p_sum_clr) else $error("sum high");

    property p_zero_st;
        @(posedge clk) disable iff (rst)
        zeroActive && alarmSelect_q[2] == ALM_ZERO
        && !alarmActiveHigh_q[2] |=> !alarmLine[2];
    endproperty
    a_zero_st: assert property (p_zero_st) else $error("zero pin");

    property p_reset;
        @(posedge clk)
        rst |=> alarmLine == ALARM_RESET && calSelect == CAL_MEASURE
        && !calStart && overScale == OVERSCALE_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset");
endmodule
`default_nettype wire

// >>> verification/dioem_master_model.sv
// Behavioural external master that drives the sense lines
`timescale 1ns/1ns
`default_nettype none
module dioem_master_model
    import dioem_pkg::*;
(
    input wire logic clk,
    output logic [SENSE_COUNT-1:0] senseLineN
);
    // Lines idle high through the pull-ups until the master pulls them
    initial begin
        senseLineN = 8'hff;
    end

    // Changes launch just after a rising edge, so sampling stays clean
    task automatic setLine(input int idx, input logic level);
        @(posedge clk);
        #2;
        senseLineN[idx] = level;
    endtask

    // Request an action: an active-low request pulls the line to ground
    task automatic requestAction(input int idx, input logic activeHigh);
        setLine(idx, activeHigh);
    endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the discrete I/O event mapper
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dioem_pkg::*;
    logic clk;
    logic rst;
    logic [SENSE_COUNT-1:0] senseLineN;
    logic cfgLoad;
    dioem_action_e senseActionIn [SENSE_COUNT];
    logic [SENSE_COUNT-1:0] senseActiveHighIn;
    dioem_alarm_e alarmSelectIn [ALARM_COUNT];
    logic [ALARM_COUNT-1:0] alarmActiveHighIn;
    logic [9:0] faults;
    logic [4:0] misc;
    logic calComplete;
    logic [15:0] aoReading [OVR_CHANNELS];
    logic [15:0] aoStandardFull [OVR_CHANNELS];
    logic [OVR_CHANNELS-1:0] overRangeEnable;
    dioem_cal_e calSelect;
    logic calStart;
    logic [ALARM_COUNT-1:0] alarmLine;
    logic [OVR_CHANNELS-1:0] overScale;
    int bad_count;
    int tests_run;
    int seed;
    dioem_cal_e expCal [$];
    logic [OVR_CHANNELS-1:0] ovrExp;
    logic [ALARM_COUNT-1:0] almExp;
    logic [15:0] readTbl [6];

    dioem_master_model master_i (.clk(clk), .senseLineN(senseLineN));

    dioem_top #(.W(16)) dioem_top_i (
        .clk(clk), .rst(rst), .senseLineN(senseLineN), .cfgLoad(cfgLoad),
        .senseActionIn(senseActionIn), .senseActiveHighIn(senseActiveHighIn),
        .alarmSelectIn(alarmSelectIn), .alarmActiveHighIn(alarmActiveHighIn),
        .highVoltFault(faults[0]), .supplyFault(faults[1]),
        .referenceFault(faults[2]), .converterFaultState(faults[3]),
        .flowFault(faults[4]), .cellHeatFault(faults[5]),
        .converterHeatFault(faults[6]), .manifoldHeatFault(faults[7]),
        .chassisTempFault(faults[8]), .coolerFault(faults[9]),
        .storageDetached(misc[0]), .backgroundActive(misc[1]),
        .spanActive(misc[2]), .zeroActive(misc[3]),
        .maintenanceActive(misc[4]), .calComplete(calComplete),
        .aoReading(aoReading), .aoStandardFull(aoStandardFull),
        .overRangeEnable(overRangeEnable), .calSelect(calSelect),
        .calStart(calStart), .alarmLine(alarmLine), .overScale(overScale)
    );

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bounded wait for every noted activation to show up
    task automatic drain();
        int i;
        for (i = 0; i < 10 && expCal.size() != 0; i++) tick(1);
        check(32'(expCal.size()), 32'h0);
    endtask

    // Instrument state selected by an alarm code, from the bench's view
    function automatic logic stateOf(input int c);
        if (c >= 1 && c <= 10) return faults[c-1];
        case (c)
            11: return misc[0];
            12: return misc[1];
            13: return misc[2];
            14: return misc[3];
            15: return |faults;
            16: return misc[4];
            17, 18, 19: return ovrExp[c-17];
            default: return 1'b0;
        endcase
    endfunction

    // Each selector pulse consumes the oldest noted expectation
    always @(posedge clk) begin
        #1;
        if (calStart === 1'b1) begin
            if (expCal.size() == 0) check(32'h1, 32'h0);
            else check(32'(calSelect), 32'(expCal.pop_front()));
        end
    end

    // Hang guard: a stuck run still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end

    initial begin
        int r;
        int k;
        seed = 32'hbfcc8946;
        rst = 1'b1;
        cfgLoad = 1'b0;
        calComplete = 1'b0;
        faults = 10'h000;
        misc = 5'h00;
        overRangeEnable = 3'h3;
        ovrExp = 3'h0;
        senseActiveHighIn = 8'h06;
        alarmActiveHighIn = 8'h00;
        readTbl = '{16'h0352, 16'h0384, 16'h0352,
                    16'h0320, 16'h0383, 16'h03e8};
        for (k = 0; k < 8; k++) begin
            senseActionIn[k] = ACT_NONE;
            alarmSelectIn[k] = ALM_NONE;
        end
        for (k = 0; k < 3; k++) begin
            aoReading[k] = 16'h0000;
            aoStandardFull[k] = 16'h03e8;
        end
        // Line 1 becomes active high, so it idles low before config lands
        master_i.setLine(1, 1'b0);
        tick(1);
        rst = 1'b0;
        check(32'(alarmLine), 32'h000000ff);
        check(32'(calSelect), 32'(CAL_MEASURE));
        check(32'(overScale), 32'h0);
        $display("test reset done");

        // Span on line 0 low, zero on line 1 high, line 2 left unused
        senseActionIn[0] = ACT_SPAN;
        senseActionIn[1] = ACT_ZERO;
        cfgLoad = 1'b1;
        tick(1);
        cfgLoad = 1'b0;
        tick(4);
        expCal.push_back(CAL_SPAN);
        master_i.requestAction(0, 1'b0);
        tick(8);
        master_i.setLine(0, 1'b1);
        tick(3);
        expCal.push_back(CAL_SPAN);
        master_i.requestAction(0, 1'b0);
        tick(2);
        master_i.setLine(0, 1'b1);
        for (k = 0; k < 4; k++) master_i.setLine(2, k[0]);
        tick(4);
        expCal.push_back(CAL_ZERO);
        master_i.requestAction(1, 1'b1);
        tick(4);
        master_i.setLine(1, 1'b0);
        drain();
        tick(4);
        check(32'(calSelect), 32'(CAL_ZERO));
        calComplete = 1'b1;
        tick(1);
        calComplete = 1'b0;
        tick(2);
        check(32'(calSelect), 32'(CAL_MEASURE));
        $display("test sense done");

        // Every alarm code, random polarity and states, hysteresis walk
        for (r = 0; r < 24; r++) begin
            for (k = 0; k < 8; k++)
                alarmSelectIn[k] = dioem_alarm_e'(5'((r * 8 + k) % 21));
            alarmActiveHighIn = 8'($random(seed));
            faults = 10'($random(seed) & $random(seed) & $random(seed));
            misc = 5'($random(seed));
            for (k = 0; k < 3; k++) aoReading[k] = readTbl[r % 6];
            cfgLoad = 1'b1;
            tick(1);
            cfgLoad = 1'b0;
            tick(3);
            for (k = 0; k < 3; k++) begin
                if (!overRangeEnable[k]) ovrExp[k] = 1'b0;
                else if (32'(aoReading[k]) * 100
                         >= 32'(aoStandardFull[k]) * 90)
                    ovrExp[k] = 1'b1;
                else if (32'(aoReading[k]) * 100
                         <= 32'(aoStandardFull[k]) * 80)
                    ovrExp[k] = 1'b0;
            end
            for (k = 0; k < 8; k++) begin
                almExp[k] = stateOf(int'(alarmSelectIn[k]));
                if (!alarmActiveHighIn[k]) almExp[k] = !almExp[k];
            end
            check(32'(overScale), 32'(ovrExp));
            check(32'(alarmLine), 32'(almExp));
        end
        $display("test alarms done");

        // Reset in mid-run returns every alarm to its inactive level
        rst = 1'b1;
        tick(2);
        check(32'(alarmLine), 32'h000000ff);
        rst = 1'b0;
        // Mappings went back to none, so pins stay inactive after release
        tick(2);
        check(32'(alarmLine), 32'h000000ff);
        check(32'(calSelect), 32'(CAL_MEASURE));
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
